// ---- rtl/spp_pkg.sv ----
// Package: constants and carrier types of the strobed parameter port
package spp_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 10;
    // Times in nanoseconds, watchdog in milliseconds, figures as printed
    localparam int STROBE_TO_OUTPUT_DELAY_NS = 1500;
    localparam int PARAM_STROBE_WIDTH_MIN_NS = 6000;
    localparam int PARAM_STROBE_WIDTH_MAX_NS = 6800;
    localparam int INPUT_VALID_WINDOW_MIN_NS = 10500;
    localparam int INPUT_VALID_WINDOW_MAX_NS = 12500;
    localparam int NO_TESTMODE_LOW_WIDTH_NS  = 35000;
    localparam int TESTMODE_LOW_WIDTH_NS     = 50000;
    localparam int WATCHDOG_MIN_MS           = 50;
    localparam int WATCHDOG_MAX_MS           = 100;

    // Cycle counts: least times round up, longest round down
    localparam int CYC_OUT_DELAY  = STROBE_TO_OUTPUT_DELAY_NS * CLK_MHZ / 1000;
    localparam int CYC_STB_MIN    =
        (PARAM_STROBE_WIDTH_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_STB_MAX    = PARAM_STROBE_WIDTH_MAX_NS * CLK_MHZ / 1000;
    localparam int CYC_SAMPLE_MIN =
        (INPUT_VALID_WINDOW_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_SAMPLE_MAX = INPUT_VALID_WINDOW_MAX_NS * CLK_MHZ / 1000;
    localparam int CYC_NOTM       = NO_TESTMODE_LOW_WIDTH_NS * CLK_MHZ / 1000;
    localparam int CYC_TM         =
        (TESTMODE_LOW_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_WDOG_DEF   = WATCHDOG_MAX_MS * 1000 * CLK_MHZ;

    // Strobe low phase of 64 cycles (6.4 us), inside 6..6.8 us
    localparam int CYC_STB_LOW    = (CYC_STB_MIN + CYC_STB_MAX) / 2;
    // Sample point, middle of the input window
    localparam int CYC_SAMPLE     = (CYC_SAMPLE_MIN + CYC_SAMPLE_MAX) / 2;
    // Whole cycle length: after sample, before next strobe
    localparam int CYC_CYCLE      = CYC_SAMPLE_MAX + 1;

    localparam int CNT_W = 8;
    localparam int WD_W  = 24;

    // ------------------------------------------------------------------
    // Configuration codes and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] IO_CONF_INPUT  = 4'h7;
    localparam logic [3:0] PARAM_RST      = 4'hF;
    localparam logic [1:0] TEST_MODES     = 2'h3;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       start;
        logic       data_req;
        logic [3:0] data;
    } spp_req_t;

    typedef struct packed {
        logic       done;
        logic       was_input;
        logic [3:0] data;
    } spp_rsp_t;

    typedef struct packed {
        logic [3:0] bit_o;
        logic [3:0] bit_oe_n;
        logic [3:0] pullup_en;
        logic       strobe_o;
        logic       strobe_oe_n;
        logic       strobe_pullup_en;
    } spp_pins_t;

endpackage

// ---- rtl/spp_sync.sv ----
// Two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
module spp_sync #(
    parameter int W = 5
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spp_sync_st_t;

    spp_sync_st_t st_q;
    spp_sync_st_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = async_i;
        st_d.s2 = st_q.s1;
    end

    // Pins idle high behind their pull-ups
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.s2;
endmodule

// ---- rtl/spp_testmode.sv ----
// Test mode stepper driven by long low phases on the strobe pin
`timescale 1ns/10ps
module spp_testmode (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       strobe_low,
    output logic      [1:0] test_mode
);
    localparam int CNT_W_L = 10;
    localparam logic [CNT_W_L-1:0] TM_CNT = CNT_W_L'(spp_pkg::CYC_TM);

    typedef struct packed {
        logic [CNT_W_L-1:0] low_cnt;
        logic               stepped;
        logic [1:0]         mode;
    } spp_tm_st_t;

    spp_tm_st_t st_q;
    spp_tm_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (!strobe_low) begin
            st_d.low_cnt = '0;
            st_d.stepped = 1'b0;
        end else if (st_q.low_cnt != TM_CNT) begin
            // Short lows, own strobes included, never reach the count
            st_d.low_cnt = st_q.low_cnt + 1'b1;
        end else if (!st_q.stepped) begin
            // One step per long pulse, however long it lasts
            st_d.stepped = 1'b1;
            st_d.mode    = (st_q.mode == spp_pkg::TEST_MODES)
                           ? 2'h0 : st_q.mode + 2'h1;
        end
    end

    // Only the hard reset, or a step past mode 3, cancels a test mode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign test_mode = st_q.mode;
endmodule

// ---- rtl/spp_top.sv ----
// Strobed four-bit parameter port with strobe, watchdog and test modes
//
// Behaviour
// - Port direction set as one unit
// - Output data valid soon after falling edge
// - Strobe low pulse lasts 6 to 6.8 us
// - Input sampled 10.5 to 12.5 us after edge
// - No drive and sample in one cycle
// - Output default; input only code 7 request
// - Data pull-ups off when configuration code is 7
// - Open-drain pins with readable input stage
// - Strobe open-drain, released, readable as input
// - Long external low pulses step test modes
// - Short low phases leave test mode alone
// - Soft reset emits one regular strobe
// - Resets release all data output stages
// - Strobe silence triggers watchdog soft reset
`timescale 1ns/10ps
module spp_top #(
    parameter int WDOG_CYCLES = spp_pkg::CYC_WDOG_DEF
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              soft_reset_req,
    input  wire logic [3:0]        io_conf,
    input  wire spp_pkg::spp_req_t req,
    input  wire logic              data_strobe_seen,
    input  wire logic [3:0]        param_bits_i,
    input  wire logic              param_strobe_n_i,
    output spp_pkg::spp_rsp_t      rsp,
    output spp_pkg::spp_pins_t     pins,
    output logic                   soft_reset_out,
    output logic                   busy,
    output logic [1:0]             test_mode
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SPP_IDLE,
        SPP_LOW,
        SPP_HIGH
    } spp_phase_t;

    typedef struct packed {
        spp_phase_t         phase;
        logic [spp_pkg::CNT_W-1:0] cnt;
        logic               dir_in;
        logic               odrive;
        logic               soft_pend;
        logic               prev_stb;
        logic [spp_pkg::WD_W-1:0]  wd_cnt;
        logic               wd_armed;
        logic [3:0]         out_data;
        spp_pkg::spp_rsp_t  rsp;
        spp_pkg::spp_pins_t pins;
        logic               soft_out;
        logic               busy;
    } spp_st_t;

    spp_st_t st_q;
    spp_st_t st_d;

    logic [4:0] pin_sync;
    logic [3:0] bits_s;
    logic       stb_s;

    localparam logic [spp_pkg::CNT_W-1:0] C_LOW =
        spp_pkg::CNT_W'(spp_pkg::CYC_STB_LOW);
    localparam logic [spp_pkg::CNT_W-1:0] C_SAMPLE =
        spp_pkg::CNT_W'(spp_pkg::CYC_SAMPLE);
    localparam logic [spp_pkg::CNT_W-1:0] C_CYCLE =
        spp_pkg::CNT_W'(spp_pkg::CYC_CYCLE);
    localparam logic [spp_pkg::WD_W-1:0] C_WDOG =
        spp_pkg::WD_W'(WDOG_CYCLES);

    // ------------------------------------------------------------------
    // Pin synchronisers and test mode stepper
    // ------------------------------------------------------------------
    spp_sync #(
        .W (5)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .async_i ({param_strobe_n_i, param_bits_i}),
        .sync_o  (pin_sync)
    );

    assign bits_s = pin_sync[3:0];
    assign stb_s  = pin_sync[4];

    spp_testmode u_tm (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .strobe_low (!stb_s),
        .test_mode  (test_mode)
    );

    // ------------------------------------------------------------------
    // Strobe cycle sequencer
    // ------------------------------------------------------------------
    always_comb begin
        st_d              = st_q;
        st_d.rsp.done     = 1'b0;
        st_d.soft_out     = 1'b0;
        st_d.prev_stb     = stb_s;

        // Watchdog: silence after a strobe forces a soft reset
        if (data_strobe_seen || (st_q.prev_stb && !stb_s)) begin
            st_d.wd_cnt   = '0;
            st_d.wd_armed = 1'b1;
        end else if (st_q.wd_armed) begin
            if (st_q.wd_cnt == C_WDOG - 1'b1) begin
                st_d.wd_armed  = 1'b0;
                st_d.soft_pend = 1'b1;
                st_d.soft_out  = 1'b1;
            end else begin
                st_d.wd_cnt = st_q.wd_cnt + 1'b1;
            end
        end

        if (soft_reset_req) begin
            st_d.soft_pend = 1'b1;
            st_d.soft_out  = 1'b1;
        end

        case (st_q.phase)
            SPP_IDLE: begin
                if (st_q.soft_pend || st_d.soft_pend) begin
                    // Reset strobe carries released data lines
                    st_d.soft_pend = 1'b0;
                    st_d.odrive    = 1'b0;
                    st_d.dir_in    = 1'b0;
                    st_d.phase     = SPP_LOW;
                    st_d.cnt       = '0;
                end else if (req.start) begin
                    st_d.dir_in   = (io_conf == spp_pkg::IO_CONF_INPUT)
                                    && req.data_req;
                    st_d.odrive   = !st_d.dir_in;
                    st_d.out_data = req.data;
                    st_d.phase    = SPP_LOW;
                    st_d.cnt      = '0;
                end
            end
            SPP_LOW: begin
                st_d.cnt = st_q.cnt + 1'b1;
                if (st_q.cnt == C_LOW - 1'b1) begin
                    st_d.phase = SPP_HIGH;
                end
            end
            SPP_HIGH: begin
                st_d.cnt = st_q.cnt + 1'b1;
                if (st_q.dir_in && st_q.cnt == C_SAMPLE) begin
                    st_d.rsp.data = bits_s;
                end
                if (st_q.cnt == C_CYCLE) begin
                    st_d.phase         = SPP_IDLE;
                    st_d.rsp.done      = 1'b1;
                    st_d.rsp.was_input = st_q.dir_in;
                end
            end
            default: begin
                st_d.phase = SPP_IDLE;
            end
        endcase

        // Soft reset releases the data output stages at once
        if (st_d.soft_out) begin
            st_d.odrive = 1'b0;
        end

        // Pin drive, all from registered state
        st_d.pins.strobe_o         = 1'b0;
        st_d.pins.strobe_oe_n      = (st_d.phase != SPP_LOW);
        st_d.pins.strobe_pullup_en = 1'b1;
        // Data changes with the falling edge and holds to the next
        if (st_d.phase == SPP_LOW && st_q.phase != SPP_LOW
            && st_d.odrive) begin
            st_d.pins.bit_o = 4'h0;
            st_d.pins.bit_oe_n = st_d.out_data;
        end
        if (!st_d.odrive) begin
            st_d.pins.bit_oe_n = 4'hF;
        end
        st_d.pins.pullup_en = (io_conf == spp_pkg::IO_CONF_INPUT)
                              ? 4'h0 : 4'hF;
        st_d.busy = (st_d.phase != SPP_IDLE);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q                       <= '0;
            st_q.phase                 <= SPP_IDLE;
            st_q.prev_stb              <= 1'b1;
            st_q.rsp.data              <= spp_pkg::PARAM_RST;
            st_q.out_data              <= spp_pkg::PARAM_RST;
            st_q.pins.bit_oe_n         <= 4'hF;
            st_q.pins.strobe_oe_n      <= 1'b1;
            st_q.pins.pullup_en        <= 4'hF;
            st_q.pins.strobe_pullup_en <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign rsp            = st_q.rsp;
    assign pins           = st_q.pins;
    assign soft_reset_out = st_q.soft_out;
    assign busy           = st_q.busy;
endmodule

// ---- dv/spp_partner.sv ----
// Sensor side model: pin levels, input answers and output capture
`timescale 1ns/10ps
module spp_partner (
    input  wire logic               sys_clk,
    input  wire spp_pkg::spp_pins_t pins,
    input  wire logic [3:0]         answer,
    input  wire logic               tm_pull,
    output logic      [3:0]         bits_w,
    output logic                    strobe_w,
    output logic      [3:0]         latched
);
    int   since = 999;
    logic noise = 1'b0;
    logic stb_q = 1'b1;

    assign strobe_w = pins.strobe_oe_n & ~tm_pull;

    // Answer held only inside the window; floating pins toggle
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!pins.bit_oe_n[i])
                bits_w[i] = 1'b0;
            else if (since >= spp_pkg::CYC_SAMPLE_MIN &&
                     since <= spp_pkg::CYC_SAMPLE_MAX)
                bits_w[i] = answer[i];
            else
                bits_w[i] = pins.pullup_en[i] | noise;
        end
    end

    always @(posedge sys_clk) begin
        noise <= ~noise;
        stb_q <= strobe_w;
        since <= (stb_q && !strobe_w) ? 1 : since + (since < 999);
        if (!stb_q && strobe_w)
            latched <= bits_w;
    end
endmodule

// ---- dv/spp_checker.sv ----
// Assertion checker for the strobed parameter port
`timescale 1ns/10ps
module spp_checker #(
    parameter int WDOG_CYCLES = spp_pkg::CYC_WDOG_DEF
) (
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic               soft_reset_req,
    input wire logic [3:0]         io_conf,
    input wire spp_pkg::spp_req_t  req,
    input wire logic               param_strobe_n_i,
    input wire spp_pkg::spp_pins_t pins,
    input wire spp_pkg::spp_rsp_t  rsp,
    input wire logic               busy,
    input wire logic [1:0]         test_mode
);
    int unsigned lo_q;
    int unsigned ext_q;
    logic [3:0]  cap_q;
    logic [1:0]  tmf_q;
    logic        in_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lo_q  <= 0;
            ext_q <= 0;
            cap_q <= 4'h0;
            tmf_q <= 2'h0;
            in_q  <= 1'b0;
        end else begin
            lo_q  <= pins.strobe_oe_n ? 0 : lo_q + 1;
            ext_q <= param_strobe_n_i ? 0 : ext_q + 1;
            if ($fell(param_strobe_n_i))
                tmf_q <= test_mode;
            if (req.start && !busy) begin
                cap_q <= req.data;
                in_q  <= io_conf == spp_pkg::IO_CONF_INPUT && req.data_req;
            end
            if (soft_reset_req)
                in_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_out_valid; $fell(pins.strobe_oe_n) && $past(req.start &&
        !busy) && !in_q |-> ##[0:15] pins.bit_oe_n == cap_q; endproperty
    a_out_valid: assert property (p_out_valid) else $error("late data");
    property p_out_hold; $changed(pins.bit_oe_n) && pins.bit_oe_n != 4'hF
        |-> $fell(pins.strobe_oe_n); endproperty
    a_out_hold: assert property (p_out_hold) else $error("data moved");
    property p_width; $rose(pins.strobe_oe_n) |->
        lo_q inside {[spp_pkg::CYC_STB_MIN:spp_pkg::CYC_STB_MAX]}; endproperty
    a_width: assert property (p_width) else $error("strobe width");
    property p_no_drive; busy && in_q |-> pins.bit_oe_n == 4'hF; endproperty
    a_no_drive: assert property (p_no_drive) else $error("drove");
    property p_dir; rsp.done |-> rsp.was_input == in_q; endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_pullup; $stable(io_conf) |-> pins.pullup_en ==
        (io_conf == 4'h7 ? 4'h0 : 4'hF); endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up");
    property p_od; pins.bit_o == 4'h0 && !pins.strobe_o &&
        pins.strobe_pullup_en; endproperty
    a_od: assert property (p_od) else $error("open drain");
    property p_tm_step; $rose(param_strobe_n_i) && ext_q >= spp_pkg::CYC_TM
        + 4 |-> ##6 test_mode == tmf_q + 2'h1; endproperty
    a_tm_step: assert property (p_tm_step) else $error("no step");
    property p_tm_hold; $changed(test_mode) |->
        $past(ext_q, 8) > spp_pkg::CYC_NOTM; endproperty
    a_tm_hold: assert property (p_tm_hold) else $error("stray step");
    property p_soft; soft_reset_req && !busy |-> ##[1:3]
        (!pins.strobe_oe_n && pins.bit_oe_n == 4'hF); endproperty
    a_soft: assert property (p_soft) else $error("soft strobe");
    c_input: cover property (rsp.done && rsp.was_input);
    c_tm: cover property ($changed(test_mode));
    c_soft: cover property (soft_reset_req);
endmodule

bind spp_top spp_checker #(.WDOG_CYCLES(WDOG_CYCLES)) i_spp_checker (
    .sys_clk, .rst, .soft_reset_req, .io_conf, .req, .param_strobe_n_i,
    .pins, .rsp, .busy, .test_mode
);

// ---- dv/strobed_parameter_port_tb.sv ----
// Self-checking testbench of the strobed parameter port
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module strobed_parameter_port_tb;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    logic               soft_reset_req = 1'b0;
    logic [3:0]         io_conf = 4'h3;
    spp_pkg::spp_req_t  req = '0;
    logic [3:0]         answer = 4'h0;
    logic               tm_pull = 1'b0;
    logic               data_seen = 1'b0;
    logic [3:0]         bits_w;
    logic               strobe_w;
    logic [3:0]         latched;
    spp_pkg::spp_rsp_t  rsp;
    spp_pkg::spp_pins_t pins;
    logic               soft_reset_out;
    logic               busy;
    logic [1:0]         test_mode;
    int                 mismatches = 0;
    int                 n_compared = 0;
    int                 n;

    always #50 sys_clk = ~sys_clk;

    // Watchdog shortened so a silent period fits the run
    spp_top #(.WDOG_CYCLES(2000)) i_spp_top (
        .sys_clk, .rst, .soft_reset_req, .io_conf, .req,
        .data_strobe_seen (data_seen),
        .param_bits_i     (bits_w),
        .param_strobe_n_i (strobe_w),
        .rsp, .pins, .soft_reset_out, .busy, .test_mode
    );
    spp_partner i_spp_partner (
        .sys_clk, .pins, .answer, .tm_pull, .bits_w, .strobe_w, .latched
    );

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic go(input logic dr, input logic [3:0] d);
        req = '{start: 1'b1, data_req: dr, data: d};
        step(1);
        req.start = 1'b0;
    endtask
    task automatic wait_until(input logic [2:0] what, input int lim);
        n = 0;
        while (n < lim && (what == 0 ? rsp.done !== 1'b1 : what == 1 ?
               pins.strobe_oe_n !== 1'b0 : soft_reset_out !== 1'b1)) begin
            step(1);
            n++;
        end
    endtask
    task automatic run(input logic dr, input logic [3:0] d);
        go(dr, d);
        wait_until(0, 400);
        `CHK(rsp.done, 1'b1)
    endtask
    task automatic pull(input int k);
        tm_pull = 1'b1;
        step(k);
        tm_pull = 1'b0;
        step(10);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_output;
        `CHK(pins.bit_oe_n, 4'hF)
        `CHK(busy, 1'b0)
        run(1'b0, 4'hA);
        `CHK(latched, 4'hA)
        go(1'b0, 4'h5);
        step(20);
        go(1'b0, 4'h0);
        wait_until(0, 400);
        `CHK(latched, 4'h5)
        `CHK(pins.bit_oe_n, 4'h5)
    endtask
    task automatic t_input;
        io_conf = 4'h7;
        for (int i = 0; i < 2; i++) begin
            answer = i ? 4'h6 : 4'h9;
            run(1'b1, 4'h0);
            `CHK(rsp.data, answer)
            `CHK(rsp.was_input, 1'b1)
            `CHK(pins.pullup_en, 4'h0)
        end
        run(1'b0, 4'hC);
        `CHK(rsp.was_input, 1'b0)
        `CHK(pins.bit_oe_n, 4'hC)
        io_conf = 4'h3;
    endtask
    task automatic t_testmode;
        pull(300);
        `CHK(test_mode, 2'h0)
        for (int i = 1; i <= 3; i++) begin
            pull(600);
            `CHK(test_mode, 2'(i))
        end
    endtask
    task automatic t_soft;
        soft_reset_req = 1'b1;
        step(1);
        soft_reset_req = 1'b0;
        wait_until(1, 5);
        `CHK(pins.bit_oe_n, 4'hF)
        n = 0;
        while (pins.strobe_oe_n === 1'b0 && n < 100) begin
            step(1);
            n++;
        end
        `CHK(n >= spp_pkg::CYC_STB_MIN && n <= spp_pkg::CYC_STB_MAX, 1'b1)
        `CHK(test_mode, 2'h3)
        pull(600);
        `CHK(test_mode, 2'h0)
    endtask
    task automatic t_wdog;
        run(1'b0, 4'h1);
        // Data strobe must restart the silence count
        step(1000);
        data_seen = 1'b1;
        step(1);
        data_seen = 1'b0;
        wait_until(2, 2500);
        `CHK(n >= 1900 && n <= 2000, 1'b1)
    endtask

    task automatic final_report;
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        step(6);
        rst = 1'b0;
        t_output();
        t_input();
        t_testmode();
        t_soft();
        t_wdog();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        final_report();
    end
endmodule
